/* File: logic/cdsf_top.sv */
// status word, packet framing and register slave of the crypto engine dma
`timescale 1ns/1ps
`default_nettype none
`include "cdsf_map.svh"

module cdsf_top
  import cdsf_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // ahb-lite slave
  input  wire logic                    hsel,
  input  wire logic [7:0]              haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // engine side events
  input  wire logic                    dma_start,
  input  wire logic                    fault_detect,
  input  wire logic [2:0]              fault_context_mode,
  input  wire logic [2:0]              fault_operation,
  input  wire logic [1:0]              fault_dma_phase,
  input  wire cdsf_bdp_state_t         descriptor_processor_state,
  // destination stream framing
  input  wire logic                    pkt_start,
  input  wire logic                    pkt_end,
  input  wire logic                    loc_step,
  output logic                         loc_write_en,
  output logic                         loc_skip,
  output logic                         frame_busy,
  output logic                         irq
);
  import cdsf_pkg::*;

  // ==========================================================
  // bus address phase capture
  logic       ph_valid_reg;
  logic       ph_write_reg;
  logic [7:0] ph_addr_reg;
  logic       ph_rd_status;

  // single cycle slave: never inserts wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // latch a valid nonseq or seq address phase
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 8'h00;
    end
    else if (hready)
    begin
      ph_valid_reg <= hsel && htrans[1] && (hsize == 3'h2);
      ph_write_reg <= hwrite;
      ph_addr_reg  <= haddr;
    end
  end

  logic bus_wr;
  assign bus_wr       = ph_valid_reg && ph_write_reg;
  assign ph_rd_status = ph_valid_reg && !ph_write_reg && (ph_addr_reg == `CDSF_OFF_STATUS);

  // ==========================================================
  // length registers
  logic [7:0] header_skip_count_reg;
  logic [7:0] trailer_skip_count_reg;

  // only the low byte is stored, so upper write bits vanish
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      header_skip_count_reg  <= `CDSF_LEN_RST;
      trailer_skip_count_reg <= `CDSF_LEN_RST;
    end
    else if (bus_wr)
    begin
      if (ph_addr_reg == `CDSF_OFF_HEADER_SKIP_COUNT)
        header_skip_count_reg <= hwdata[7:0];
      if (ph_addr_reg == `CDSF_OFF_TRLLEN)
        trailer_skip_count_reg <= hwdata[7:0];
    end
  end

  // ==========================================================
  // fault capture
  logic       fault_held_reg;
  logic [2:0] fault_mode_reg;
  logic [2:0] fault_op_reg;
  logic [1:0] fault_phase_reg;
  logic       op_legal;

  // reserved operation codes are never reported
  assign op_legal = (fault_operation == `CDSF_OP_ENC) || (fault_operation == `CDSF_OP_DEC)
                 || (fault_operation == `CDSF_OP_AUTH);

  // first error wins; later errors are dropped until software reads the status word
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fault_held_reg  <= 1'b0;
      fault_mode_reg  <= 3'h0;
      fault_op_reg    <= 3'h0;
      fault_phase_reg <= 2'h0;
    end
    else if (fault_detect && (!fault_held_reg || ph_rd_status))
    begin
      fault_held_reg  <= 1'b1;
      fault_mode_reg  <= fault_context_mode[2] ? 3'h0 : fault_context_mode;
      fault_op_reg    <= op_legal ? fault_operation : 3'h0;
      fault_phase_reg <= fault_dma_phase;
    end
    else if (ph_rd_status)
    begin
      fault_held_reg <= 1'b0;
    end
  end

  // ==========================================================
  // start flag and live state
  logic            started_reg;
  cdsf_bdp_state_t bdp_state_reg;

  // the start bit stays until reset; state is registered to keep reads glitch free
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      started_reg   <= 1'b0;
      bdp_state_reg <= BDP_IDLE;
    end
    else
    begin
      if (dma_start)
        started_reg <= 1'b1;
      bdp_state_reg <= (descriptor_processor_state > BDP_SA_FETCH) ? BDP_IDLE
                     : descriptor_processor_state;
    end
  end

  logic [31:0] crypto_engine_status;
  always_comb
  begin
    crypto_engine_status = 32'h0000_0000;
    crypto_engine_status[`CDSF_MODE_LSB +: 3]  = fault_mode_reg;
    crypto_engine_status[`CDSF_OP_LSB +: 3]    = fault_op_reg;
    crypto_engine_status[`CDSF_PHASE_LSB +: 2] = fault_phase_reg;
    crypto_engine_status[`CDSF_STATE_LSB +: 4] = bdp_state_reg;
    crypto_engine_status[`CDSF_START_BIT]      = started_reg;
  end

  // ==========================================================
  // packet framing
  cdsf_frame_t frame_reg;
  logic [7:0]  skip_left_reg;

  // the header skip count is sampled at packet start and the trailer count at packet end, so a write cannot tear a running skip
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      frame_reg     <= FR_HEAD;
      skip_left_reg <= 8'h00;
    end
    else
    begin
      case (frame_reg)
        FR_HEAD:
        begin
          if (pkt_start)
          begin
            skip_left_reg <= header_skip_count_reg;
            frame_reg     <= FR_BODY;
          end
        end
        FR_BODY:
        begin
          if (loc_step && skip_left_reg != 8'h00)
            skip_left_reg <= skip_left_reg - 8'h01;
          else if (pkt_end)
          begin
            skip_left_reg <= trailer_skip_count_reg;
            frame_reg     <= FR_TAIL;
          end
        end
        FR_TAIL:
        begin
          if (skip_left_reg == 8'h00)
            frame_reg <= FR_HEAD;
          else if (loc_step)
            skip_left_reg <= skip_left_reg - 8'h01;
        end
        default:
          frame_reg <= FR_HEAD;
      endcase
    end
  end

  // a step while skipping advances the address without writing
  assign loc_skip     = loc_step && (skip_left_reg != 8'h00)
                     && (frame_reg != FR_HEAD);
  assign loc_write_en = loc_step && (frame_reg == FR_BODY) && (skip_left_reg == 8'h00);
  assign frame_busy   = (frame_reg != FR_HEAD);

  // ==========================================================
  // interrupts: bit0 fault detected, bit1 dma start
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_evt;
  logic [1:0] irq_clr;

  assign irq_evt = {dma_start, fault_detect};
  assign irq_clr = (bus_wr && ph_addr_reg == `CDSF_OFF_IRQSTAT) ? hwdata[1:0] : 2'h0;

  // set beats a simultaneous write-one clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_stat_reg <= `CDSF_IRQ_RST;
      irq_mask_reg <= `CDSF_IRQ_RST;
    end
    else
    begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
      if (bus_wr && ph_addr_reg == `CDSF_OFF_IRQMASK)
        irq_mask_reg <= hwdata[1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================
  // read data mux, registered? no: data phase returns held registers directly
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (ph_valid_reg && !ph_write_reg)
    begin
      case (ph_addr_reg)
        `CDSF_OFF_STATUS:  hrdata = crypto_engine_status;
        `CDSF_OFF_HEADER_SKIP_COUNT:  hrdata = {24'h00_0000, header_skip_count_reg};
        `CDSF_OFF_TRLLEN:  hrdata = {24'h00_0000, trailer_skip_count_reg};
        `CDSF_OFF_IRQSTAT: hrdata = {30'h0000_0000, irq_stat_reg};
        `CDSF_OFF_IRQMASK: hrdata = {30'h0000_0000, irq_mask_reg};
        default:           hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : cdsf_top
`default_nettype wire

/* File: logic/cdsf_map.svh */
// register offsets, field positions and reset values of the crypto dma status block
`ifndef CDSF_MAP_SVH
`define CDSF_MAP_SVH
// byte offsets on the register bus
`define CDSF_OFF_STATUS   8'h00
`define CDSF_OFF_HEADER_SKIP_COUNT   8'h04
`define CDSF_OFF_TRLLEN   8'h08
`define CDSF_OFF_IRQSTAT  8'h0C
`define CDSF_OFF_IRQMASK  8'h10
// status word field positions
`define CDSF_MODE_LSB     29
`define CDSF_OP_LSB       26
`define CDSF_PHASE_LSB    24
`define CDSF_STATE_LSB    18
`define CDSF_START_BIT    17
// reset values
`define CDSF_LEN_RST      8'h00
`define CDSF_IRQ_RST      2'h0
// operation codes that may be reported
`define CDSF_OP_ENC       3'h1
`define CDSF_OP_DEC       3'h2
`define CDSF_OP_AUTH      3'h4
`endif

/* File: logic/cdsf_pkg.sv */
// types of the crypto dma status and framing block
package cdsf_pkg;
  // descriptor processor states, in the order of their status codes
  typedef enum logic [3:0] {
    BDP_IDLE, BDP_FETCH_PEND, BDP_LOADING, BDP_DATA, BDP_DONE, BDP_FETCH_OFF, BDP_SA_FETCH
  } cdsf_bdp_state_t;
  // framing position inside one packet on the destination side
  typedef enum logic [1:0] {
    FR_HEAD, FR_BODY, FR_TAIL
  } cdsf_frame_t;
endpackage : cdsf_pkg

/* File: verification/cdsf_top_sva.sv */
// assertion checker for the crypto dma status and framing block
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker
module cdsf_top_sva (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        dma_start,
  input wire logic        pkt_start,
  input wire logic        loc_step,
  input wire logic        loc_write_en,
  input wire logic        loc_skip,
  input wire logic        frame_busy
);
  logic [7:0] ra_reg;
  logic       rv_reg;
  logic       st_reg;
  // read data shows one cycle after its address phase, so keep that phase
  always_ff @(posedge mclk)
  begin
    rv_reg <= !rst && hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
    ra_reg <= haddr;
    st_reg <= !rst && (st_reg || dma_start);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_resp_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_skip_excl: assert property (!(loc_skip && loc_write_en))
    else $error("skip and write together");
  a_idle_quiet: assert property (!frame_busy |-> !loc_skip && !loc_write_en)
    else $error("location activity while idle");
  a_step_cause: assert property (loc_skip || loc_write_en |-> loc_step)
    else $error("location activity without step");
  a_start_busy: assert property (pkt_start && !frame_busy |=> frame_busy)
    else $error("packet start not taken");
  a_stat_zero: assert property (rv_reg && ra_reg == 8'h00 |-> hrdata[23:22] == 2'h0)
    else $error("status bits 23:22 not zero");
  a_len_upper: assert property (rv_reg && ra_reg inside {8'h04, 8'h08} |->
    hrdata[31:8] == 24'h0) else $error("length upper bits not zero");
  a_start_bit: assert property (rv_reg && ra_reg == 8'h00 |-> hrdata[17] == st_reg)
    else $error("start bit wrong");
  a_code_legal: assert property (rv_reg && ra_reg == 8'h00 |-> !hrdata[31] &&
    hrdata[28:26] inside {3'h0, 3'h1, 3'h2, 3'h4} && hrdata[21:18] < 4'h7)
    else $error("reserved status code shown");
  c_stat_read: cover property (rv_reg && ra_reg == 8'h00 && hrdata[17]);
  c_loc_write: cover property (loc_write_en);
  c_frame_end: cover property (frame_busy ##1 !frame_busy);
endmodule : cdsf_top_sva
bind cdsf_top cdsf_top_sva cdsf_top_sva_inst (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hready, .hrdata, .hreadyout, .hresp, .dma_start, .pkt_start, .loc_step,
  .loc_write_en, .loc_skip, .frame_busy);
`default_nettype wire

/* File: verification/cdsf_mem_model.sv */
// destination memory model that takes the framed location stream
`timescale 1ns/1ps
`default_nettype none
// ====================
// memory model
module cdsf_mem_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       step_en,
  input  wire logic       loc_write_en,
  input  wire logic       loc_skip,
  output logic            loc_step,
  output logic [7:0]      wr_cnt,
  output logic [7:0]      skip_cnt
);
  // always-ready memory: one location per enabled cycle, stalls when not enabled
  assign loc_step = step_en;
  // tally written and skipped locations for the bench
  always_ff @(posedge mclk)
  begin
    wr_cnt   <= rst ? 8'h00 : wr_cnt + 8'(loc_step && loc_write_en);
    skip_cnt <= rst ? 8'h00 : skip_cnt + 8'(loc_step && loc_skip);
  end
endmodule : cdsf_mem_model
`default_nettype wire

/* File: verification/tb_cdsf_top.sv */
// self-checking bench for the crypto dma status and framing block
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench top
module tb_cdsf_top;
  import cdsf_pkg::*;
  logic            mclk, rst, hsel, hwrite, dma_start, fault_detect, pkt_start, pkt_end;
  logic            step_en, hreadyout, hresp, loc_step, loc_write_en, loc_skip, frame_busy, irq;
  logic [7:0]      haddr, wr_cnt, skip_cnt;
  logic [1:0]      htrans, fault_dma_phase;
  logic [2:0]      hsize, fault_context_mode, fault_operation;
  logic [31:0]     hwdata, hrdata, q;
  cdsf_bdp_state_t descriptor_processor;
  int              err_count, comparisons, i;
  cdsf_top cdsf_top_inst (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dma_start, .fault_detect,
    .fault_context_mode, .fault_operation, .fault_dma_phase,
    .descriptor_processor_state(descriptor_processor), .pkt_start, .pkt_end, .loc_step, .loc_write_en,
    .loc_skip, .frame_busy, .irq);
  cdsf_mem_model cdsf_mem_model_inst (.mclk, .rst, .step_en, .loc_write_en, .loc_skip,
    .loc_step, .wr_cnt, .skip_cnt);
  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // single word transfer: address held until hready, then data held until hready
  // ready and read data are taken in the settled half before the edge, not racing it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do
    begin
      @(negedge mclk);
      rdy = hreadyout;
      @(posedge mclk);
    end
    while (rdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(negedge mclk);
      rdy = hreadyout;
      q   = hrdata;
      @(posedge mclk);
    end
    while (rdy !== 1'b1);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    #100000;
    err_count++;
    end_sim();
  end
  // ====================
  // tests
  initial
  begin
    err_count = 0;
    comparisons = 0;
    rst = 1'b1;
    {hsel, hwrite, dma_start, fault_detect, pkt_start, pkt_end, step_en} = '0;
    {haddr, htrans, hwdata, fault_context_mode, fault_operation, fault_dma_phase} = '0;
    hsize = 3'h2;
    descriptor_processor = BDP_IDLE;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 24; i += 4)
      rd(8'(i), 32'h0);
    bus(1'b1, 8'h04, 32'hFFFF_FFA5);
    bus(1'b1, 8'h08, 32'h1234_5601);
    bus(1'b1, 8'h14, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0000_00A5);
    rd(8'h08, 32'h0000_0001);
    rd(8'h14, 32'h0);
    $display("test registers done");
    // every mode, phase and operation; a second fault must not displace the first
    for (i = 0; i < 4; i++)
    begin
      descriptor_processor <= cdsf_bdp_state_t'(4'(i * 2));
      dma_start <= (i == 2);
      fault_detect <= 1'b1;
      fault_context_mode <= 3'(i);
      fault_operation <= 3'h1 << (i % 3);
      fault_dma_phase <= 2'(i);
      @(posedge mclk);
      dma_start <= 1'b0;
      fault_context_mode <= 3'h3;
      fault_operation <= 3'h2;
      @(posedge mclk);
      fault_detect <= 1'b0;
      rd(8'h00, {3'(i), 3'h1 << (i % 3), 2'(i), 2'h0, 4'(i * 2), 1'(i >= 2), 17'h0});
    end
    $display("test status done");
    rd(8'h0C, 32'h3);
    #1 chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h10, 32'h1);
    #1 chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h0C, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
    rd(8'h0C, 32'h2);
    $display("test interrupt done");
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b1, 8'h08, 32'h1);
    pkt_start <= 1'b1;
    @(posedge mclk);
    pkt_start <= 1'b0;
    step_en <= 1'b1;
    repeat (5) @(posedge mclk);
    step_en <= 1'b0;
    pkt_end <= 1'b1;
    @(posedge mclk);
    pkt_end <= 1'b0;
    step_en <= 1'b1;
    @(posedge mclk);
    step_en <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({24'h0, wr_cnt}, 32'h3);
    chk({24'h0, skip_cnt}, 32'h3);
    #1 chk({31'h0, frame_busy}, 32'h0);
    $display("test framing done");
    end_sim();
  end
endmodule : tb_cdsf_top
`default_nettype wire
